/* shared/edge_count_pkg.sv */
package edge_count_pkg;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MAXV = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_INIT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SWRST = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;
    // control field positions
    localparam int CTL_EDGE_LO = 0;
    localparam int CTL_DIR_EN = 2;
    localparam int CTL_DIR_POL = 3;
    localparam int CTL_RST_EN = 4;
    localparam int CTL_RST_LO = 5;
    localparam int CTL_W = 7;
    // edge selections
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    // reset values
    localparam logic [CTL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [31:0] MAXV_RST = 32'h0000ffff;
    localparam logic [31:0] INIT_RST = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/edge_count_core.sv */
`timescale 1ns/10ps
module edge_count_core
    import edge_count_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic pulse_in,
    input wire logic dir_in,
    input wire logic [1:0] edge_sel,
    input wire logic dir_en,
    input wire logic dir_pol,
    input wire logic reload,
    input wire logic [W-1:0] max_val,
    input wire logic [W-1:0] init_val,
    output logic [W-1:0] count
);
    logic [1:0] p_sync_q, p_sync_d;
    logic [1:0] d_sync_q, d_sync_d;
    logic p_last_q, p_last_d;
    logic started_q, started_d;
    logic [W-1:0] cnt_q, cnt_d;
    logic hit;
    logic up;

    // two-flop synchronisers, edges taken on second stage only
    always_comb begin
        p_sync_d = {p_sync_q[0], pulse_in};
        d_sync_d = {d_sync_q[0], dir_in};
        p_last_d = p_sync_q[1];
        case (edge_sel)
            EDGE_RISE: hit = p_sync_q[1] & ~p_last_q;
            EDGE_FALL: hit = ~p_sync_q[1] & p_last_q;
            EDGE_BOTH: hit = p_sync_q[1] ^ p_last_q;
            default: hit = 1'b0;
        endcase
        // direction level meaning set by polarity bit
        up = dir_en ? (d_sync_q[1] ^ dir_pol) : 1'b1;
        started_d = started_q;
        cnt_d = cnt_q;
        if (reload) begin
            cnt_d = init_val;
            started_d = 1'b0;
        end else if (hit) begin
            started_d = 1'b1;
            if (up) begin
                cnt_d = (cnt_q >= max_val) ? '0 : W'(cnt_q + 1'b1);
            end else begin
                cnt_d = (cnt_q == '0) ? max_val : W'(cnt_q - 1'b1);
            end
        end else if (!started_q) begin
            cnt_d = init_val;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            p_sync_q <= 2'h0;
            d_sync_q <= 2'h0;
            p_last_q <= 1'b0;
            started_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            p_sync_q <= p_sync_d;
            d_sync_q <= d_sync_d;
            p_last_q <= p_last_d;
            started_q <= started_d;
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
endmodule

/* rtl/edge_count_top.sv */
// Overview of operation
// - count rising, falling or both edges of pulse input as configured
// - present count is always readable by software
// - with direction on, each edge counts up or down by direction level
// - direction input can be disabled; then counting is up only
// - polarity bit chooses which direction level means up
// - configurable maximum value is the wrap point
// - count holds the initial value until the first counted edge
// - a software reset reloads the initial value, not zero
// - software reset fires on its rising, falling or either edge
// - reset rises on zero to non-zero, falls on non-zero to zero
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module edge_count_top
    import edge_count_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic PULSE_IN,
    input wire logic DIR_IN,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    logic [CTL_W-1:0] ctrl_q, ctrl_d;
    logic [31:0] maxv_q, maxv_d;
    logic [31:0] init_q, init_d;
    logic [31:0] swrst_q, swrst_d;
    logic reload_q, reload_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic aw_have_q, aw_have_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic w_have_q, w_have_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [W-1:0] count;
    logic [W-1:0] count_q;
    logic rst_rise;
    logic rst_fall;
    logic [31:0] newrst;

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // address is one of the mapped words
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == OFS_CTRL || a == OFS_MAXV || a == OFS_INIT ||
               a == OFS_SWRST || a == OFS_COUNT;
    endfunction

    // write channel capture, register update and software reset edges
    always_comb begin
        awaddr_d = awaddr_q;
        aw_have_d = aw_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        w_have_d = w_have_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        maxv_d = maxv_q;
        init_d = init_q;
        swrst_d = swrst_q;
        newrst = swrst_q;
        rst_rise = 1'b0;
        rst_fall = 1'b0;
        // take items only while ready is shown; ready is low in the first cycle after reset
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            awaddr_d = S_AXI_AWADDR;
            aw_have_d = 1'b1;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            wdata_d = S_AXI_WDATA;
            wstrb_d = S_AXI_WSTRB;
            w_have_d = 1'b1;
        end
        if (aw_have_q && w_have_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            case (awaddr_q)
                OFS_CTRL: ctrl_d = CTL_W'(merge(32'(ctrl_q), wdata_q,
                                                wstrb_q));
                OFS_MAXV: maxv_d = merge(maxv_q, wdata_q, wstrb_q);
                OFS_INIT: init_d = merge(init_q, wdata_q, wstrb_q);
                OFS_SWRST: begin
                    newrst = merge(swrst_q, wdata_q, wstrb_q);
                    swrst_d = newrst;
                end
                default: begin
                end
            endcase
        end else if (bvalid_q && S_AXI_BREADY) begin
            bvalid_d = 1'b0;
        end
        // zero versus non-zero decides the edge
        rst_rise = (swrst_q == '0) && (newrst != '0);
        rst_fall = (swrst_q != '0) && (newrst == '0);
        case (ctrl_q[CTL_RST_LO +: 2])
            EDGE_RISE: reload_d = rst_rise;
            EDGE_FALL: reload_d = rst_fall;
            EDGE_BOTH: reload_d = rst_rise | rst_fall;
            default: reload_d = 1'b0;
        endcase
        reload_d = reload_d & ctrl_q[CTL_RST_EN];
    end

    // read channel, one cycle to answer
    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (rvalid_q) begin
            if (S_AXI_RREADY) begin
                rvalid_d = 1'b0;
            end
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_d = 1'b1;
            rresp_d = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            case (S_AXI_ARADDR)
                OFS_CTRL: rdata_d = 32'(ctrl_q);
                OFS_MAXV: rdata_d = maxv_q;
                OFS_INIT: rdata_d = init_q;
                OFS_SWRST: rdata_d = swrst_q;
                OFS_COUNT: rdata_d = 32'(count_q);
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ctrl_q <= CTRL_RST;
            maxv_q <= MAXV_RST;
            init_q <= INIT_RST;
            swrst_q <= 32'h00000000;
            reload_q <= 1'b0;
            awaddr_q <= '0;
            aw_have_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
            count_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            maxv_q <= maxv_d;
            init_q <= init_d;
            swrst_q <= swrst_d;
            reload_q <= reload_d;
            awaddr_q <= awaddr_d;
            aw_have_q <= aw_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            w_have_q <= w_have_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            count_q <= count;
        end
    end

    edge_count_core #(
        .W(W)
    ) u_core (
        .clk(CLOCK),
        .srst(SRST),
        .pulse_in(PULSE_IN),
        .dir_in(DIR_IN),
        .edge_sel(ctrl_q[CTL_EDGE_LO +: 2]),
        .dir_en(ctrl_q[CTL_DIR_EN]),
        .dir_pol(ctrl_q[CTL_DIR_POL]),
        .reload(reload_q),
        .max_val(maxv_q[W-1:0]),
        .init_val(init_q[W-1:0]),
        .count(count)
    );

    // handshake outputs straight from flops
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_ARREADY <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_have_d && !bvalid_d;
            S_AXI_WREADY <= !w_have_d && !bvalid_d;
            S_AXI_ARREADY <= !rvalid_d;
        end
    end

    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;
endmodule

/* testbench/edge_count_props.sv */
`timescale 1ns/10ps
module edge_count_props
    import edge_count_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    // bus answers: timing, holding, blocking
    b_hold_a: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    w_answer_a: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##2 S_AXI_BVALID)
        else $error("write answer late");
    b_block_a: assert property (
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while answer pending");
    r_hold_a: assert property (
        S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer changed");
    r_answer_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    r_once_a: assert property (
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read answer repeated");
    r_block_a: assert property (
        S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while answer pending");
    err_zero_a: assert property (
        S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
        else $error("refused read carries data");
    // main scenarios reached
    cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
    cover property (S_AXI_BVALID && S_AXI_BREADY);
    cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule

/* testbench/pulse_source.sv */
`timescale 1ns/10ps
module pulse_source (
    input wire logic clk,
    output logic pulse,
    output logic dir
);
    // pin levels from time zero
    initial begin
        pulse = 1'b0;
        dir = 1'b1;
    end
    // one whole pulse, high held gap cycles, low held twice gap cycles
    task automatic send(input int gap);
        pulse <= 1'b1;
        repeat (gap) @(posedge clk);
        pulse <= 1'b0;
        repeat (gap * 2) @(posedge clk);
    endtask
    // direction settles before the next pulse
    task automatic set_dir(input logic lvl);
        dir <= lvl;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* testbench/edge_count_tb.sv */
`timescale 1ns/10ps
module edge_count_tb
    import edge_count_pkg::*;
;
    logic clk, srst, awv, wv, by, arv, ry;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, want;
    logic [3:0] ws;
    logic [1:0] br, rr, rsp;
    logic awr, wrd, bv, arr, rv, pulse, dir;
    int n_fail = 0, checks = 0;
    // system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    pulse_source src (.clk(clk), .pulse(pulse), .dir(dir));
    edge_count_top dut (
        .CLOCK(clk), .SRST(srst), .PULSE_IN(pulse), .DIR_IN(dir),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(by), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(ry)
    );
    // compare and count
    task automatic check(input logic [31:0] s, input logic [31:0] w);
        checks++;
        if (s !== w) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, w);
        end
    endtask
    // bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        by <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        by <= 1'b0;
        rsp = br;
    endtask
    // bus read with data compare
    task automatic rchk(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        ry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        ry <= 1'b0;
        rsp = rr;
        check(rdat, w);
    endtask
    // count readout after the pin path settles
    task automatic cnt(input logic [31:0] w);
        repeat (8) @(posedge clk);
        rchk(OFS_COUNT, w);
    endtask
    task automatic test_done;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #100000;
        n_fail++;
        test_done;
    end
    // main sequence
    initial begin
        srst = 1'b1;
        awv = 1'b0;
        wv = 1'b0;
        by = 1'b0;
        arv = 1'b0;
        ry = 1'b0;
        awa = 8'h00;
        ara = 8'h00;
        wd = 32'h00000000;
        ws = 4'hf;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rchk(OFS_MAXV, MAXV_RST);
        wr(OFS_INIT, 32'h5);
        cnt(32'h5);
        want = 32'h5;
        for (int e = 0; e < 3; e++) begin
            wr(OFS_CTRL, 32'(e));
            src.send(e == 1 ? 5 : 2);
            want = want + ((e == 2) ? 32'h2 : 32'h1);
            cnt(want);
        end
        wr(OFS_MAXV, 32'ha);
        wr(OFS_CTRL, 32'h0);
        src.send(2);
        src.send(2);
        cnt(32'h0);
        wr(OFS_CTRL, 32'h4);
        src.set_dir(1'b0);
        src.send(2);
        cnt(32'ha);
        src.set_dir(1'b1);
        src.send(2);
        cnt(32'h0);
        wr(OFS_CTRL, 32'hc);
        src.send(2);
        cnt(32'ha);
        wr(OFS_CTRL, 32'h0);
        src.set_dir(1'b0);
        src.send(2);
        cnt(32'h0);
        want = 32'h0;
        for (int r = 0; r < 3; r++) begin
            wr(OFS_CTRL, 32'h10 | 32'(r << 5));
            src.send(2);
            wr(OFS_SWRST, 32'h3);
            want = (r == 1) ? want + 32'h1 : 32'h5;
            cnt(want);
            src.send(2);
            wr(OFS_SWRST, 32'h0);
            want = (r == 0) ? want + 32'h1 : 32'h5;
            cnt(want);
        end
        wr(OFS_CTRL, 32'h3);
        src.send(2);
        cnt(32'h5);
        wr(OFS_COUNT, 32'h9);
        check(32'(rsp), 32'(RESP_OKAY));
        cnt(32'h5);
        wr(8'h20, 32'h1);
        check(32'(rsp), 32'(RESP_SLVERR));
        rchk(8'h20, 32'h0);
        check(32'(rsp), 32'(RESP_SLVERR));
        // single byte lane write merges into the old word
        ws <= 4'h2;
        wr(OFS_MAXV, 32'h00001234);
        ws <= 4'hf;
        rchk(OFS_MAXV, 32'h0000120a);
        // second reset in mid-run
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rchk(OFS_CTRL, 32'(CTRL_RST));
        cnt(INIT_RST);
        test_done;
    end
endmodule
bind edge_count_top edge_count_props chk (
    .CLOCK, .SRST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY
);
